// ===== hw/keypad_interrupt_unit.sv
/*
 keypad_interrupt_unit: twenty-pin keypad interrupt logic over three ports
 (d: 8 pins, e: 4 pins, f: 8 pins) with an APB register slave.
 Assumes pins are asynchronous to pclk, the cpu pulses a vector fetch
 acknowledge per port for one pclk cycle, and pads are driven elsewhere.
*/
// Decided for this implementation: the APB slave port.
//
// Contract
// RULE1 - twenty maskable inputs, latch and mask per port
// RULE2 - port d enable also enables pull-up
// RULE3 - port e/f pull-ups, f register resets ones
// RULE4 - each enable bit arms its pin
// RULE5 - latch on first low; edge mode ignores others
// RULE6 - level mode holds request while pin low
// RULE7 - level mode clears after ack and release
// RULE8 - edge mode ack clears request at once
// RULE9 - write-only ack bit two clears, reads zero
// RULE10 - later falling edges latch new request
// RULE11 - unmasked request fetches vector, fetch acknowledges
// RULE12 - reset clears latch and sensitivity bit
// RULE13 - flag bit three shows pending, ignores mask
// RULE14 - mask bit one blocks cpu request
// RULE15 - sensitivity bit zero selects edge or level
// RULE16 - status bits seven to four read zero
// RULE17 - enable forces input; read needs direction zero
// RULE18 - software masks, enables, acks, then unmasks
// RULE19 - port d may drive high before enabling
// RULE20 - level mode ack delayed for load
// RULE21 - reset clears port d enable register
// RULE22 - ports e, f mirror port d logic
// RULE23 - port e vector at its own addresses
`timescale 1ns/1ns
module keypad_interrupt_unit
   import keypad_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // keypad pins, low means key pressed
   input wire logic [7:0] port_d_pins,
   input wire logic [3:0] port_e_pins,
   input wire logic [7:0] port_f_pins,
   // cpu vector fetch acknowledges, one pulse each
   input wire logic [2:0] vector_fetch_ack,
   // cpu interrupt requests: d, e, f
   output logic [2:0] cpu_irq,
   // pad controls
   output logic [7:0] port_d_pullup_on,
   output logic [3:0] port_e_pullup_on,
   output logic [7:0] port_f_pullup_on,
   output logic [7:0] port_d_force_input,
   output logic [3:0] port_e_force_input,
   output logic [7:0] port_f_force_input
);
   // three-stage pin synchronisers; stages two and three are compared
   logic [19:0] sync1_reg;
   logic [19:0] sync2_reg;
   logic [19:0] sync3_reg;
   logic [19:0] level_reg;
   logic [19:0] level_next;
   logic [19:0] stages_agree;
   logic [19:0] pins_raw;
   assign pins_raw = {port_f_pins, port_e_pins, port_d_pins};

   // ones at reset match the idle level of a released key, so no false
   // falling edge follows reset
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_reg <= '1;
      end else begin
         sync1_reg <= pins_raw;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync2_reg <= '1;
      end else begin
         sync2_reg <= sync1_reg;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync3_reg <= '1;
      end else begin
         sync3_reg <= sync2_reg;
      end
   end

   // a change counts only once stages two and three agree; a pin that
   // bounces every cycle never reaches the request logic
   assign stages_agree = ~(sync2_reg ^ sync3_reg);
   assign level_next = (stages_agree & sync2_reg)
                     | (~stages_agree & level_reg);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         level_reg <= '1;
      end else begin
         level_reg <= level_next;
      end
   end

   // configuration registers
   logic [7:0] d_enable_reg, e_enable_reg, f_enable_reg, f_pullup_reg;
   logic [7:0] d_dir_reg;
   logic [2:0] mask_reg, sens_reg, pend_reg, port_d_acknowledge_reg, low_reg;

   // apb decode: read data is fetched in setup so that it stands with
   // pready; a write lands only at the access edge that sees pready high,
   // so an aborted transfer never changes a register
   logic setup_phase;
   logic access_done;
   logic wr_strobe;
   logic rd_strobe;
   logic [9:0] word_idx;
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & pready;
   assign wr_strobe = access_done & pwrite;
   assign rd_strobe = setup_phase & ~pwrite;
   assign word_idx = paddr[11:2];

   function automatic logic hit(input logic [9:0] idx, input logic [7:0] r);
      return idx == {2'b00, r};
   endfunction

   logic [2:0] sc_hit;
   logic d_en_hit, e_en_hit, f_en_hit, f_pu_hit, lvl_hit, dir_hit, mapped;
   assign sc_hit[0] = hit(word_idx, port_d_keypad_status_control_idx);
   assign sc_hit[1] = hit(word_idx, port_e_keypad_status_control_idx);
   assign sc_hit[2] = hit(word_idx, port_f_keypad_status_control_idx);
   assign d_en_hit = hit(word_idx, port_d_keypad_pin_enable_idx);
   assign e_en_hit = hit(word_idx, port_e_keypad_pin_and_pullup_enable_idx);
   assign f_en_hit = hit(word_idx, port_f_keypad_pin_enable_idx);
   assign f_pu_hit = hit(word_idx, port_f_pullup_enable_idx);
   assign lvl_hit = hit(word_idx, pin_level_idx);
   assign dir_hit = hit(word_idx, port_d_direction_idx);
   assign mapped = |sc_hit | d_en_hit | e_en_hit | f_en_hit | f_pu_hit
                 | lvl_hit | dir_hit;

   // per-port enabled-pin view; port e uses only its low four bits
   logic [7:0] en [3];
   logic [7:0] lv [3];
   assign en[0] = d_enable_reg;
   assign en[1] = {4'h0, e_enable_reg[3:0]};
   assign en[2] = f_enable_reg;
   assign lv[0] = level_reg[7:0];
   assign lv[1] = {4'hf, level_reg[11:8]};
   assign lv[2] = level_reg[19:12];

   logic [2:0] any_low, fall, ack, pend_next, low_next;
   logic [2:0] ack_write;
   // level mode keeps a latched or acknowledged request while pins are low
   logic [2:0] hold_low;
   assign hold_low = pend_reg | port_d_acknowledge_reg;
   genvar p;
   generate
      for (p = 0; p < 3; p++) begin : g_port
         assign any_low[p] = |(en[p] & ~lv[p]); // see RULE4
         // latch only when some enabled pin goes low after all high
         assign fall[p] = any_low[p] & ~low_reg[p]; // see RULE5
         assign ack_write[p] = wr_strobe & sc_hit[p] & pwdata[acknowledge_bit];
         assign ack[p] = ack_write[p] | vector_fetch_ack[p]; // see RULE9
         // new fall wins over ack; level mode holds while any pin low
         assign pend_next[p] = fall[p] ? 1'b1 // see RULE10
            : (sens_reg[p] & any_low[p]) ? hold_low[p] // see RULE6
            : (sens_reg[p] & port_d_acknowledge_reg[p]) ? 1'b0 // see RULE7
            : ack[p] ? 1'b0 // see RULE8
            : pend_reg[p];
         assign low_next[p] = any_low[p];
      end
   endgenerate

   // ack seen in level mode waits for all pins high before clearing
   logic [2:0] port_d_acknowledge_next;
   assign port_d_acknowledge_next = (port_d_acknowledge_reg | (ack & pend_reg & sens_reg)) & any_low
                      & sens_reg & ~fall;

   // reset drops a request even while a key is still held low
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 3'h0; // see RULE12
      end else begin
         pend_reg <= pend_next; // see RULE1
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_d_acknowledge_reg <= 3'h0;
      end else begin
         port_d_acknowledge_reg <= port_d_acknowledge_next;
      end
   end

   // low at reset: a key held through reset is seen as a new fall once
   // it is enabled, which software masks and acknowledges away
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_reg <= 3'h0;
      end else begin
         low_reg <= low_next;
      end
   end

   // a selected register takes the low byte of the bus, else holds
   function automatic logic [7:0] byte_write(input logic sel,
                                             input logic [7:0] wdata,
                                             input logic [7:0] old);
      return sel ? wdata : old;
   endfunction

   logic [7:0] d_enable_next;
   logic [7:0] e_enable_next;
   logic [7:0] f_enable_next;
   logic [7:0] f_pullup_next;
   logic [7:0] d_dir_next;
   logic [2:0] sc_write;
   logic [2:0] mask_next;
   logic [2:0] sens_next;
   assign d_enable_next = byte_write(wr_strobe & d_en_hit, pwdata[7:0],
                                     d_enable_reg); // see RULE4
   assign e_enable_next = byte_write(wr_strobe & e_en_hit, pwdata[7:0],
                                     e_enable_reg);
   assign f_enable_next = byte_write(wr_strobe & f_en_hit, pwdata[7:0],
                                     f_enable_reg);
   assign f_pullup_next = byte_write(wr_strobe & f_pu_hit, pwdata[7:0],
                                     f_pullup_reg); // see RULE3
   assign d_dir_next = byte_write(wr_strobe & dir_hit, pwdata[7:0],
                                  d_dir_reg);
   // the acknowledge bit is not stored: it only strobes ack_write
   assign sc_write = {3{wr_strobe}} & sc_hit;
   assign mask_next = (sc_write & {3{pwdata[mask_bit]}})
                    | (~sc_write & mask_reg); // see RULE14
   assign sens_next = (sc_write & {3{pwdata[sensitivity_bit]}})
                    | (~sc_write & sens_reg); // see RULE15

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d_enable_reg <= pin_enable_reset; // see RULE21
      end else begin
         d_enable_reg <= d_enable_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         e_enable_reg <= pin_enable_reset;
      end else begin
         e_enable_reg <= e_enable_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_enable_reg <= pin_enable_reset;
      end else begin
         f_enable_reg <= f_enable_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         f_pullup_reg <= port_f_pullup_reset; // see RULE3
      end else begin
         f_pullup_reg <= f_pullup_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         d_dir_reg <= direction_reset;
      end else begin
         d_dir_reg <= d_dir_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mask_reg <= 3'h0; // see RULE14
      end else begin
         mask_reg <= mask_next;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sens_reg <= 3'h0; // see RULE12
      end else begin
         sens_reg <= sens_next;
      end
   end

   // read mux; ack reads zero, upper bits zero
   function automatic logic [7:0] sc_read(input logic pend, input logic m,
                                          input logic s);
      logic [7:0] v;
      v = 8'h00; // see RULE16
      v[pending_bit] = pend; // see RULE13
      v[mask_bit] = m;
      v[sensitivity_bit] = s;
      return v;
   endfunction

   // port d level readable only where direction is input
   logic [7:0] d_visible;
   assign d_visible = level_reg[7:0] & ~d_dir_reg; // see RULE17

   logic [7:0] rd_byte;
   assign rd_byte = sc_hit[0] ? sc_read(pend_reg[0], mask_reg[0], sens_reg[0])
                  : sc_hit[1] ? sc_read(pend_reg[1], mask_reg[1], sens_reg[1])
                  : sc_hit[2] ? sc_read(pend_reg[2], mask_reg[2], sens_reg[2])
                  : d_en_hit ? d_enable_reg
                  : e_en_hit ? e_enable_reg
                  : f_en_hit ? f_enable_reg
                  : f_pu_hit ? f_pullup_reg
                  : dir_hit ? d_dir_reg
                  : lvl_hit ? d_visible
                  : 8'h00;

   // registered answer: pready in the access cycle after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup_phase;
         pslverr <= setup_phase & ~mapped;
         if (rd_strobe) prdata <= {24'h0, rd_byte};
      end
   end

   // cpu requests use pend_next so a request rises with its flag; every
   // output comes straight from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cpu_irq <= 3'h0;
      end else begin
         // vector fetch at d, e, f vectors acknowledges via vector_fetch_ack
         cpu_irq <= pend_next & ~mask_reg; // see RULE11 RULE14 RULE22 RULE23
      end
   end

   // port d pull-ups follow its enables; e and f have bits of their own
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_d_pullup_on <= 8'h00;
         port_e_pullup_on <= 4'h0;
         port_f_pullup_on <= port_f_pullup_reset;
      end else begin
         port_d_pullup_on <= d_enable_reg; // see RULE2
         port_e_pullup_on <= e_enable_reg[7:4]; // see RULE3
         port_f_pullup_on <= f_pullup_reg; // see RULE3
      end
   end

   // an enabled pin is forced to an input whatever its direction bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         port_d_force_input <= 8'h00;
         port_e_force_input <= 4'h0;
         port_f_force_input <= 8'h00;
      end else begin
         port_d_force_input <= d_enable_reg; // see RULE17
         port_e_force_input <= e_enable_reg[3:0];
         port_f_force_input <= f_enable_reg;
      end
   end
endmodule

// ===== shared/keypad_pkg.sv
/*
 keypad_pkg: register indices, field positions, reset values and the
 per-port carrier types of the keypad interrupt unit.
 Assumes a 32-bit APB master; byte address is four times the index.
*/
package keypad_pkg;
   // register indices (byte address = index * 4)
   localparam logic [7:0] port_d_keypad_status_control_idx = 8'h0c;
   localparam logic [7:0] port_d_keypad_pin_enable_idx = 8'h0d;
   localparam logic [7:0] port_e_keypad_status_control_idx = 8'h0e;
   localparam logic [7:0] port_e_keypad_pin_and_pullup_enable_idx = 8'h0f;
   localparam logic [7:0] port_f_keypad_status_control_idx = 8'h40;
   localparam logic [7:0] port_f_keypad_pin_enable_idx = 8'h41;
   localparam logic [7:0] port_f_pullup_enable_idx = 8'h42;
   // own register: synchronised port d pin levels, read only
   localparam logic [7:0] pin_level_idx = 8'h43;
   // own register: port d direction bits
   localparam logic [7:0] port_d_direction_idx = 8'h44;
   // status/control field positions
   localparam int sensitivity_bit = 0;
   localparam int mask_bit = 1;
   localparam int acknowledge_bit = 2;
   localparam int pending_bit = 3;
   // reset values
   localparam logic [7:0] status_control_reset = 8'h00;
   localparam logic [7:0] pin_enable_reset = 8'h00;
   localparam logic [7:0] port_f_pullup_reset = 8'hff;
   localparam logic [7:0] direction_reset = 8'h00;

   typedef struct packed {
      logic [7:0] enables;
      logic mask;
      logic sensitivity;
   } port_cfg_type;

   typedef struct packed {
      logic [7:0] pullups;
      logic [7:0] input_force;
      logic request;
   } port_out_type;
endpackage

// ===== testbench/keypad_interrupt_unit_tb.sv
/*
 keypad_interrupt_unit_tb: apb register tests and key presses.
 Assumes the keypad_switches model and the bound checker.
*/
`timescale 1ns/1ns
module keypad_interrupt_unit_tb;
   logic pclk = 0;
   logic presetn = 0;
   logic psel = 0;
   logic penable = 0;
   logic pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [2:0] vector_fetch_ack = 3'h0;
   logic [19:0] press = 20'h0;
   logic [19:0] pins;
   logic [31:0] prdata;
   logic pready, pslverr, last_err;
   logic [2:0] cpu_irq;
   logic [7:0] pu_d, pu_f;
   logic [3:0] pu_e;
   // port d pins driven high as outputs before their enables are set
   logic [7:0] drive_d = 8'h00;
   int n_errors = 0;
   int checks = 0;
   logic [11:0] sta [3] = '{12'h030, 12'h038, 12'h100};
   logic [11:0] ena [3] = '{12'h034, 12'h03c, 12'h104};
   logic [7:0] env [3] = '{8'h01, 8'hf1, 8'h01};
   int bit_of [3] = '{0, 8, 12};
   initial forever #2 pclk = ~pclk;
   keypad_switches keys(.pclk(pclk), .press(press),
      .pull_on({pu_f, pu_e, pu_d | drive_d}), .pins(pins));
   keypad_interrupt_unit DUT(.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port_d_pins(pins[7:0]), .port_e_pins(pins[11:8]),
      .port_f_pins(pins[19:12]), .vector_fetch_ack(vector_fetch_ack),
      .cpu_irq(cpu_irq), .port_d_pullup_on(pu_d), .port_e_pullup_on(pu_e),
      .port_f_pullup_on(pu_f), .port_d_force_input(),
      .port_e_force_input(), .port_f_force_input());
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      if (n_errors == 0 && checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the watchdog ends a wait for pready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      last_err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      xfer(1'b1, a, d, r);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h0, r);
      chk(r, e);
   endtask
   // pins pass a synchroniser, so give them a settle time
   task automatic keys_to(input logic [19:0] p);
      press <= p;
      repeat (6) @(posedge pclk);
   endtask
   task automatic fetch(input int i);
      vector_fetch_ack[i] <= 1'b1;
      @(posedge pclk);
      vector_fetch_ack[i] <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic irq_is(input logic [2:0] e);
      @(negedge pclk);
      chk(cpu_irq, e);
      @(posedge pclk);
   endtask
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (int i = 0; i < 3; i++) begin
         rd(sta[i], 32'h0);
         rd(ena[i], 32'h0);
      end
      rd(12'h108, 32'hff);
      rd(12'h200, 32'h0);
      chk(last_err, 1'b1);
      wr(12'h030, 32'h02);
      wr(12'h034, 32'h81);
      wr(12'h030, 32'h06);
      wr(12'h030, 32'h00);
      keys_to(20'h00001);
      rd(12'h030, 32'h08);
      irq_is(3'h1);
      fetch(0);
      irq_is(3'h0);
      keys_to(20'h00081);
      rd(12'h030, 32'h00);
      keys_to(20'h00000);
      keys_to(20'h00080);
      rd(12'h030, 32'h08);
      wr(12'h030, 32'h02);
      rd(12'h030, 32'h0a);
      irq_is(3'h0);
      wr(12'h030, 32'h06);
      rd(12'h030, 32'h02);
      keys_to(20'h0);
      wr(12'h030, 32'h01);
      keys_to(20'h00001);
      wr(12'h030, 32'h05);
      rd(12'h030, 32'h09);
      irq_is(3'h1);
      keys_to(20'h0);
      rd(12'h030, 32'h01);
      keys_to(20'h00001);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      rd(12'h030, 32'h00);
      rd(12'h034, 32'h00);
      keys_to(20'h0);
      drive_d <= 8'h01;
      wr(12'h110, 32'h01);
      keys_to(20'h0);
      wr(12'h034, 32'h01);
      rd(12'h030, 32'h00);
      rd(12'h10c, 32'hfe);
      drive_d <= 8'h00;
      wr(12'h110, 32'h00);
      rd(12'h10c, 32'hff);
      for (int i = 1; i < 3; i++) begin
         wr(ena[i], {24'h0, env[i]});
         keys_to(20'h1 << bit_of[i]);
         rd(sta[i], 32'h08);
         irq_is(3'h1 << i);
         fetch(i);
         irq_is(3'h0);
         keys_to(20'h0);
      end
      test_done();
   end
   initial begin
      repeat (5000) @(posedge pclk);
      n_errors++;
      test_done();
   end
endmodule

// ===== testbench/keypad_properties.sv
/*
 keypad_properties: port-level checks of keypad_interrupt_unit.
 Assumes one apb setup cycle, then an access cycle.
*/
`timescale 1ns/1ns
module keypad_properties(
   // watched ports
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic [2:0] cpu_irq,
   input wire logic [7:0] port_d_pullup_on,
   input wire logic [3:0] port_e_pullup_on,
   input wire logic [7:0] port_f_pullup_on,
   input wire logic [7:0] port_d_force_input,
   input wire logic [3:0] port_e_force_input,
   input wire logic [7:0] port_f_force_input
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr_done = psel && penable && pwrite && pready;
   wire rd_done = pready && !pwrite;
   chk_d_pull_force: assert property (
      port_d_pullup_on == port_d_force_input)
      else $error("port d pull-up differs from input force");
   chk_reset_values: assert property (
      $rose(presetn) |-> port_f_pullup_on == 8'hff
      && port_d_pullup_on == 8'h00 && cpu_irq == 3'h0)
      else $error("wrong pad or request state after reset");
   chk_d_enable_wr: assert property (
      wr_done && paddr == 12'h034 |-> ##2
      port_d_force_input == $past(pwdata[7:0], 2))
      else $error("port d enable write not applied");
   chk_e_enable_wr: assert property (
      wr_done && paddr == 12'h03c |-> ##2
      {port_e_pullup_on, port_e_force_input} == $past(pwdata[7:0], 2))
      else $error("port e enable write not applied");
   chk_f_enable_wr: assert property (
      wr_done && paddr == 12'h104 |-> ##2
      port_f_force_input == $past(pwdata[7:0], 2))
      else $error("port f enable write not applied");
   chk_f_pullup_wr: assert property (
      wr_done && paddr == 12'h108 |-> ##2
      port_f_pullup_on == $past(pwdata[7:0], 2))
      else $error("port f pull-up write not applied");
   chk_status_zeros: assert property (
      rd_done && paddr inside {12'h030, 12'h038, 12'h100} |->
      prdata[31:4] == 28'h0 && !prdata[2])
      else $error("status read shows bits that read zero");
   chk_mask_blocks: assert property (
      rd_done && paddr == 12'h030 && prdata[1] |-> !cpu_irq[0])
      else $error("masked port d request reached the cpu");
   cover property ($rose(cpu_irq[0]));
   cover property ($rose(cpu_irq[1]));
   cover property ($rose(cpu_irq[2]));
endmodule
bind keypad_interrupt_unit keypad_properties chk_inst(.*);

// ===== testbench/keypad_switches.sv
/*
 keypad_switches: twenty keys on the port pins, d in 7:0, e in 11:8, f above.
 Assumes pull-up enables come straight from the pad controls.
*/
`timescale 1ns/1ns
module keypad_switches(
   // clock, key presses and pad pull-ups
   input wire logic pclk,
   input wire logic [19:0] press,
   input wire logic [19:0] pull_on,
   // pins
   output logic [19:0] pins
);
   logic [19:0] wobble = 20'h0;
   always @(posedge pclk) begin
      wobble <= ~wobble;
   end
   // released key floats unless pulled up, so it must not read a clean high
   assign pins = ~press & (pull_on | wobble);
endmodule
